// *** core/serial_channel_pkg.sv ***
// Register map, field positions and constants of the serial channel
package serial_channel_pkg;

  // Register byte offsets
  localparam logic [7:0] ADDR_BUF   = 8'h00;
  localparam logic [7:0] ADDR_CTRL  = 8'h04;
  localparam logic [7:0] ADDR_MODE  = 8'h08;
  localparam logic [7:0] ADDR_MODE2 = 8'h0c;
  localparam logic [7:0] ADDR_TST   = 8'h10;
  localparam logic [7:0] ADDR_DMA   = 8'h14;
  localparam logic [7:0] ADDR_BAUD  = 8'h18;

  // serial_control_reg fields
  localparam int CR_PE   = 0;
  localparam int CR_EVEN = 1;
  localparam int CR_PARITY_ERROR_FLAG = 2;
  localparam int CR_FIFO_RX_ERROR_SUMMARY = 3;
  localparam int CR_RB8  = 4;
  localparam int CR_TB7  = 5;
  localparam int CR_RXF  = 6;
  localparam int CR_FERR = 7;

  // serial_mode_reg fields
  localparam int MD_MODE = 0;
  localparam int MD_MSB  = 2;
  localparam int MD_SCLK = 3;
  localparam int MD_RXE  = 4;
  localparam int MD_WAKE = 5;
  localparam int MD_TB8  = 6;

  // serial_mode_reg_two fields
  localparam int M2_STOP_LENGTH_SELECT = 0;
  localparam int M2_TFCS  = 1;

  // tx_fifo_status and dma_request_enable fields
  localparam int TST_TUR = 7;
  localparam int TST_LVL = 0;
  localparam int LVL_W   = 3;
  localparam int DMA_TX  = 0;
  localparam int DMA_RX  = 1;

  // Values after reset and sizes
  localparam logic        TUR_RST    = 1'b1;
  localparam logic [15:0] BAUD_RST   = 16'h0004;
  localparam int          FIFO_DEF   = 4;
  localparam logic [3:0]  SYNC_BITS  = 4'h8;

  typedef enum logic [1:0] {
    MODE_SYNC,
    MODE_7BIT,
    MODE_8BIT,
    MODE_9BIT
  } mode_t;

endpackage : serial_channel_pkg

// *** core/tx_fifo_mem.sv ***
// Small storage array for the transmit FIFO with registered read data
`timescale 1ns/1ns
module tx_fifo_mem #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4,
  parameter int AW    = 2
)(
  input  wire logic             hclk,
  input  wire logic             hresetn,
  input  wire logic             we,
  input  wire logic [AW-1:0]    waddr,
  input  wire logic [WIDTH-1:0] wdata,
  input  wire logic [AW-1:0]    raddr,
  output logic      [WIDTH-1:0] rdata
);

  logic [WIDTH-1:0] mem_r [DEPTH];

  always_ff @(posedge hclk)
  begin
    if (we)
    begin
      mem_r[waddr] <= wdata;
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rdata <= '0;
    end
    else
    begin
      rdata <= mem_r[raddr];
    end
  end

endmodule : tx_fifo_mem

// *** core/serial_channel.sv ***
// Serial channel: AHB-Lite registers, transmit FIFO, shifters, parity, DMA
`timescale 1ns/1ns
module serial_channel
  import serial_channel_pkg::*;
#(
  parameter int CHANNEL    = 0,
  parameter int FIFO_DEPTH = FIFO_DEF
)(
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  input  wire logic        rxd,
  output logic             txd,
  input  wire logic        sclk_in,
  output logic             sclk_out,
  output logic             sclk_oe,
  input  wire logic        dma_busy,
  output logic             dma_rx_req,
  output logic             dma_tx_req,
  output logic             receive_irq,
  output logic             transmit_irq
);

  localparam int  AW     = $clog2(FIFO_DEPTH);
  localparam bit  DMA_OK = (CHANNEL != 1) && (CHANNEL != 3);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} rx_st_t;

  function automatic logic hit(input logic [31:0] a, input logic [7:0] off);
    return (a[31:8] == 24'h0) && (a[7:0] == off);
  endfunction : hit

  function automatic logic [7:0] bitrev(input logic [7:0] d);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++)
    begin
      r[i] = d[7-i];
    end
    return r;
  endfunction : bitrev

  // Register state
  logic        pe_r, even_r, parity_error_flag_r, fifo_rx_error_summary_r, ferr_r, rb8_r, tb7_r;
  logic        rx_full_r, msb_r, sclko_r, rxe_r, wake_r, tb8_r, stop_length_select_r;
  logic        tur_r;
  logic [1:0]  dma_en_r;
  logic [15:0] baud_r;
  logic [7:0]  rx_data_r;
  mode_t       mode_r;

  // Bus state
  logic        acc_w_r;
  logic [31:0] acc_a_r;
  logic [31:0] hrdata_r;

  // Transmit state
  logic [AW-1:0]    wr_ptr_r, rd_ptr_r;
  logic [LVL_W-1:0] cnt_r;
  logic             avail_r;
  logic [7:0]       fifo_rd;
  logic             tx_busy_r, tx_par_r, sclk_r;
  logic [11:0]      tx_sh_r;
  logic [3:0]       tx_left_r;
  logic [15:0]      baud_cnt_r;

  // Receive state
  rx_st_t      rx_st_r;
  logic [15:0] rx_cnt_r;
  logic [3:0]  rx_n_r;
  logic [8:0]  rx_sh_r;
  logic        rx_done_r, rx_stop_r;
  logic        rxd_m_r, rxd_s_r, sclk_m_r, sclk_s_r, sclk_d_r;
  logic        tx_evt_r, rx_evt_r, dma_tx_r, dma_rx_r;

  // Address phase and data phase decode
  wire addr_ph = hsel && htrans[1] && hready;
  wire rd_acc  = addr_ph && !hwrite;
  wire wr_buf  = acc_w_r && hit(acc_a_r, ADDR_BUF);
  wire wr_ctrl = acc_w_r && hit(acc_a_r, ADDR_CTRL);
  wire wr_mode = acc_w_r && hit(acc_a_r, ADDR_MODE);
  wire wr_md2  = acc_w_r && hit(acc_a_r, ADDR_MODE2);
  wire wr_dma  = acc_w_r && hit(acc_a_r, ADDR_DMA);
  wire wr_baud = acc_w_r && hit(acc_a_r, ADDR_BAUD);
  wire rd_buf  = rd_acc && hit(haddr, ADDR_BUF);

  wire is_sync = (mode_r == MODE_SYNC);
  wire is_7    = (mode_r == MODE_7BIT);
  wire is_8    = (mode_r == MODE_8BIT);
  wire is_9    = (mode_r == MODE_9BIT);
  wire par_on  = pe_r && (is_7 || is_8);

  // FIFO control
  wire fifo_clr = wr_md2 && hwdata[M2_TFCS];
  wire fifo_ful = (cnt_r == LVL_W'(FIFO_DEPTH));
  wire push     = wr_buf && !fifo_ful && !fifo_clr;
  wire tx_load  = !tx_busy_r && (cnt_r != '0) && avail_r;

  // Clock edges for shifting
  wire tick     = (baud_cnt_r == 16'h0);
  wire master   = is_sync && sclko_r;
  wire m_rise   = master && tx_busy_r && tick && !sclk_r;
  wire m_fall   = master && tx_busy_r && tick && sclk_r;
  wire s_rise   = master ? m_rise : (sclk_s_r && !sclk_d_r);
  wire tx_step  = is_sync ? s_rise : tick;
  wire tx_done  = tx_busy_r && tx_step && (tx_left_r == 4'h1);

  // Frame assembly from the FIFO head
  wire p7 = ^fifo_rd[6:0] ^ ~even_r;
  wire p8 = ^fifo_rd ^ ~even_r;
  logic [8:0]  pay;
  logic [3:0]  plen;
  logic [11:0] frame;
  logic [3:0]  flen;

  always_comb
  begin
    pay  = 9'h1ff;
    plen = 4'h8;
    case (mode_r)
      MODE_7BIT:
      begin
        pay  = {1'b1, par_on ? p7 : 1'b1, fifo_rd[6:0]};
        plen = par_on ? 4'h8 : 4'h7;
      end
      MODE_8BIT:
      begin
        pay  = {par_on ? p8 : 1'b1, fifo_rd};
        plen = par_on ? 4'h9 : 4'h8;
      end
      MODE_9BIT:
      begin
        pay  = {tb8_r, fifo_rd};
        plen = 4'h9;
      end
      default:
      begin
        pay  = {1'b1, msb_r ? bitrev(fifo_rd) : fifo_rd};
        plen = SYNC_BITS;
      end
    endcase
  end

  // Async: start, data LSB first, parity, then 1 or 2 stop bits
  assign frame = is_sync ? {4'hf, pay[7:0]} : {2'b11, pay, 1'b0};
  assign flen  = is_sync ? SYNC_BITS
               : plen + 4'h2 + {3'h0, stop_length_select_r};

  // Received frame alignment and checks
  wire [8:0] rx_al   = rx_sh_r >> (4'h9 - plen);
  wire [7:0] rx_byte = (is_sync && msb_r) ? bitrev(rx_al[7:0])
                     : rx_al[7:0];
  wire rx_x    = is_7 ? ^rx_al[7:0] : ^rx_al;
  wire par_err = par_on && (rx_x ^ ~even_r);
  wire rx_drop = is_9 && wake_r && !rx_al[8];
  wire rx_keep = rx_done_r && !rx_drop;
  wire fr_err  = rx_keep && !is_sync && !rx_stop_r;

  // Read word assembly, unused bits stay zero
  logic [31:0] ctrl_w, mode_w, md2_w, tst_w, dma_w, rd_mux;

  always_comb
  begin
    ctrl_w = '0;
    mode_w = '0;
    md2_w  = '0;
    tst_w  = '0;
    dma_w  = '0;
    ctrl_w[CR_PE]   = pe_r;
    ctrl_w[CR_EVEN] = even_r;
    ctrl_w[CR_PARITY_ERROR_FLAG] = parity_error_flag_r;
    ctrl_w[CR_FIFO_RX_ERROR_SUMMARY] = fifo_rx_error_summary_r;
    ctrl_w[CR_RB8]  = rb8_r;
    ctrl_w[CR_TB7]  = tb7_r;
    ctrl_w[CR_RXF]  = rx_full_r;
    ctrl_w[CR_FERR] = ferr_r;
    mode_w[MD_MODE+:2] = mode_r;
    mode_w[MD_MSB]  = msb_r;
    mode_w[MD_SCLK] = sclko_r;
    mode_w[MD_RXE]  = rxe_r;
    mode_w[MD_WAKE] = wake_r;
    mode_w[MD_TB8]  = tb8_r;
    md2_w[M2_STOP_LENGTH_SELECT] = stop_length_select_r;
    tst_w[TST_TUR]  = tur_r;
    tst_w[TST_LVL+:LVL_W] = cnt_r;
    dma_w[DMA_TX+:2] = dma_en_r;
  end

  assign rd_mux = hit(haddr, ADDR_BUF)   ? {24'h0, rx_data_r} :
                  hit(haddr, ADDR_CTRL)  ? ctrl_w :
                  hit(haddr, ADDR_MODE)  ? mode_w :
                  hit(haddr, ADDR_MODE2) ? md2_w  :
                  hit(haddr, ADDR_TST)   ? tst_w  :
                  hit(haddr, ADDR_DMA)   ? dma_w  :
                  hit(haddr, ADDR_BAUD)  ? {16'h0, baud_r} : 32'h0;

  assign hrdata       = hrdata_r;
  assign hreadyout    = 1'b1;
  assign hresp        = 1'b0;
  assign txd          = tx_sh_r[0];
  assign sclk_out     = sclk_r;
  assign sclk_oe      = master;
  assign dma_rx_req   = dma_rx_r;
  assign dma_tx_req   = dma_tx_r;
  assign receive_irq  = rx_evt_r;
  assign transmit_irq = tx_evt_r;

  // Bus pipeline: write data is taken in the data phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      acc_w_r  <= 1'b0;
      acc_a_r  <= '0;
      hrdata_r <= '0;
    end
    else
    begin
      acc_w_r <= addr_ph && hwrite;
      if (addr_ph)
      begin
        acc_a_r <= haddr;
      end
      if (rd_acc)
      begin
        hrdata_r <= rd_mux;
      end
    end
  end

  // Software controls; hardware parity store overrides a same-cycle write
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      pe_r <= 1'b0; even_r <= 1'b0; mode_r <= MODE_SYNC; msb_r <= 1'b0;
      sclko_r <= 1'b0; rxe_r <= 1'b0; wake_r <= 1'b0; tb8_r <= 1'b0;
      tb7_r <= 1'b0; stop_length_select_r <= 1'b0; dma_en_r <= '0; baud_r <= BAUD_RST;
    end
    else
    begin
      if (wr_ctrl)
      begin
        pe_r   <= hwdata[CR_PE];
        even_r <= hwdata[CR_EVEN];
      end
      if (wr_mode)
      begin
        mode_r  <= mode_t'(hwdata[MD_MODE+:2]);
        msb_r   <= hwdata[MD_MSB];
        sclko_r <= hwdata[MD_SCLK];
        rxe_r   <= hwdata[MD_RXE];
        wake_r  <= hwdata[MD_WAKE];
        tb8_r   <= hwdata[MD_TB8];
      end
      if (wr_md2)
      begin
        stop_length_select_r <= hwdata[M2_STOP_LENGTH_SELECT];
      end
      if (wr_dma)
      begin
        dma_en_r <= hwdata[DMA_TX+:2];
      end
      if (wr_baud)
      begin
        baud_r <= hwdata[15:0];
      end
      if (tx_done && par_on && is_7)
      begin
        tb7_r <= tx_par_r;
      end
      if (tx_done && par_on && is_8)
      begin
        tb8_r <= tx_par_r;
      end
    end
  end

  // Transmit FIFO pointers and fill level
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      avail_r  <= 1'b0;
    end
    else if (fifo_clr)
    begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
      avail_r  <= 1'b0;
    end
    else
    begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(tx_load);
      cnt_r    <= cnt_r + LVL_W'(push) - LVL_W'(tx_load);
      avail_r  <= (cnt_r != '0);
    end
  end

  tx_fifo_mem #(
    .WIDTH (8),
    .DEPTH (FIFO_DEPTH),
    .AW    (AW)
  ) u_tx_mem (
    .hclk    (hclk),
    .hresetn (hresetn),
    .we      (push),
    .waddr   (wr_ptr_r),
    .wdata   (hwdata[7:0]),
    .raddr   (rd_ptr_r),
    .rdata   (fifo_rd)
  );

  // Bit rate divider, restarted at each frame load
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      baud_cnt_r <= '0;
    end
    else if (tx_load || tick)
    begin
      baud_cnt_r <= baud_r - 16'h1;
    end
    else
    begin
      baud_cnt_r <= baud_cnt_r - 16'h1;
    end
  end

  // Transmit shifter; idle line and stop bits are ones
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_busy_r <= 1'b0;
      tx_sh_r   <= 12'hfff;
      tx_left_r <= '0;
      tx_par_r  <= 1'b0;
      sclk_r    <= 1'b1;
    end
    else
    begin
      if (tx_load)
      begin
        tx_busy_r <= 1'b1;
        tx_sh_r   <= frame;
        tx_left_r <= flen;
        tx_par_r  <= is_7 ? p7 : p8;
      end
      else if (tx_busy_r && tx_step)
      begin
        tx_sh_r   <= {1'b1, tx_sh_r[11:1]};
        tx_left_r <= tx_left_r - 4'h1;
        tx_busy_r <= !tx_done;
      end
      if (m_fall || m_rise)
      begin
        sclk_r <= !sclk_r;
      end
    end
  end

  // Underrun: a finished frame with nothing queued; set wins over clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tur_r <= TUR_RST;
    end
    else if (tx_done && (cnt_r == '0))
    begin
      tur_r <= 1'b1;
    end
    else if (wr_buf)
    begin
      tur_r <= 1'b0;
    end
  end

  // Input synchronisers
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      {rxd_m_r, rxd_s_r} <= 2'b11;
      {sclk_m_r, sclk_s_r, sclk_d_r} <= 3'b111;
    end
    else
    begin
      rxd_m_r  <= rxd;
      rxd_s_r  <= rxd_m_r;
      sclk_m_r <= sclk_in;
      sclk_s_r <= sclk_m_r;
      sclk_d_r <= sclk_s_r;
    end
  end

  // Receive shifter: mode 0 on clock rises, async by mid-bit sampling
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_st_r   <= RX_IDLE;
      rx_cnt_r  <= '0;
      rx_n_r    <= '0;
      rx_sh_r   <= '0;
      rx_done_r <= 1'b0;
      rx_stop_r <= 1'b1;
    end
    else
    begin
      rx_done_r <= 1'b0;
      rx_cnt_r  <= rx_cnt_r - 16'h1;
      case (rx_st_r)
        RX_IDLE:
        begin
          if (rxe_r && is_sync && s_rise)
          begin
            rx_sh_r   <= {rxd_s_r, rx_sh_r[8:1]};
            rx_n_r    <= (rx_n_r == SYNC_BITS - 4'h1) ? 4'h0 : rx_n_r + 4'h1;
            rx_done_r <= (rx_n_r == SYNC_BITS - 4'h1);
          end
          else if (rxe_r && !is_sync && !rxd_s_r)
          begin
            rx_cnt_r <= {1'b0, baud_r[15:1]};
            rx_st_r  <= RX_START;
          end
        end
        RX_START:
        begin
          if (rx_cnt_r == 16'h0)
          begin
            rx_cnt_r <= baud_r - 16'h1;
            rx_n_r   <= '0;
            rx_st_r  <= rxd_s_r ? RX_IDLE : RX_DATA;
          end
        end
        RX_DATA:
        begin
          if (rx_cnt_r == 16'h0)
          begin
            rx_sh_r  <= {rxd_s_r, rx_sh_r[8:1]};
            rx_n_r   <= rx_n_r + 4'h1;
            rx_cnt_r <= baud_r - 16'h1;
            if (rx_n_r == plen - 4'h1)
            begin
              rx_st_r <= RX_STOP;
            end
          end
        end
        RX_STOP:
        begin
          if (rx_cnt_r == 16'h0)
          begin
            rx_stop_r <= rxd_s_r;
            rx_done_r <= 1'b1;
            rx_n_r    <= '0;
            rx_st_r   <= RX_IDLE;
          end
        end
        default:
        begin
          rx_st_r <= RX_IDLE;
        end
      endcase
    end
  end

  // Receive buffer and error flags; hardware set wins over software clear
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      rx_data_r <= '0; rb8_r <= 1'b0; rx_full_r <= 1'b0;
      parity_error_flag_r <= 1'b0; fifo_rx_error_summary_r <= 1'b0; ferr_r <= 1'b0;
    end
    else
    begin
      if (rx_keep)
      begin
        rx_data_r <= rx_byte;
        rb8_r     <= rx_al[8];
      end
      if (rx_keep)
        rx_full_r <= 1'b1;
      else if (rd_buf)
        rx_full_r <= 1'b0;
      if (rx_keep && par_err)
        parity_error_flag_r <= 1'b1;
      else if (wr_ctrl && hwdata[CR_PARITY_ERROR_FLAG])
        parity_error_flag_r <= 1'b0;
      if (rx_keep && par_err)
        fifo_rx_error_summary_r <= 1'b1;
      else if (wr_ctrl && hwdata[CR_FIFO_RX_ERROR_SUMMARY])
        fifo_rx_error_summary_r <= 1'b0;
      if (fr_err)
        ferr_r <= 1'b1;
      else if (wr_ctrl && hwdata[CR_FERR])
        ferr_r <= 1'b0;
    end
  end

  // Events and DMA requests; a request during a busy transfer is lost
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      tx_evt_r <= 1'b0;
      rx_evt_r <= 1'b0;
      dma_tx_r <= 1'b0;
      dma_rx_r <= 1'b0;
    end
    else
    begin
      tx_evt_r <= tx_load;
      rx_evt_r <= rx_keep;
      dma_tx_r <= DMA_OK && tx_load && dma_en_r[DMA_TX]
                  && !dma_busy;
      dma_rx_r <= DMA_OK && rx_keep && dma_en_r[DMA_RX]
                  && !dma_busy;
    end
  end

endmodule : serial_channel

// *** dv/serial_channel_assertions.sv ***
// Port checks for the serial channel
`timescale 1ns/1ns
module serial_channel_assertions
  import serial_channel_pkg::*;
#(
  parameter int CHANNEL = 0
)(
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic        rxd,
  input wire logic        txd,
  input wire logic        sclk_in,
  input wire logic        sclk_out,
  input wire logic        sclk_oe,
  input wire logic        dma_busy,
  input wire logic        dma_rx_req,
  input wire logic        dma_tx_req,
  input wire logic        receive_irq,
  input wire logic        transmit_irq
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  wire rd_go = hsel && htrans[1] && hready && !hwrite;
  sequence rd_taken(logic [7:0] a);
    rd_go && haddr == {24'h0, a};
  endsequence
  sequence dma_pulse;
    dma_rx_req || dma_tx_req;
  endsequence
  okay_resp_a: assert property (hresp == 1'b0)
    else $error("Response is not OKAY");
  zero_wait_a: assert property (hreadyout)
    else $error("Wait state inserted");
  tst_fields_a: assert property (rd_taken(ADDR_TST) |=>
    hrdata[31:8] == 24'h0 && hrdata[6:3] == 4'h0 && hrdata[2:0] <= 3'h4)
    else $error("Fill status read out of range");
  dma_fields_a: assert property (rd_taken(ADDR_DMA) |=>
    hrdata[31:2] == 30'h0) else $error("Enable register spare bits set");
  unmapped_zero_a: assert property (rd_go && haddr[31:8] != 24'h0 |=>
    hrdata == 32'h0) else $error("Unmapped read not zero");
  rdata_hold_a: assert property (!rd_go |=> $stable(hrdata))
    else $error("Read data moved without a read");
  busy_drop_a: assert property (dma_pulse |-> !$past(dma_busy))
    else $error("Request raised during transfer");
  rx_dma_tie_a: assert property (dma_rx_req |-> receive_irq)
    else $error("Receive request without receive event");
  tx_dma_tie_a: assert property (dma_tx_req |-> transmit_irq)
    else $error("Transmit request without transmit event");
  no_dma_chan_a: assert property ((CHANNEL == 1 || CHANNEL == 3) |->
    !dma_rx_req && !dma_tx_req) else $error("Request on channel without DMA");
  irq_pulse_a: assert property (receive_irq |=> !receive_irq)
    else $error("Receive event longer than a cycle");
endmodule : serial_channel_assertions

// *** dv/serial_partner.sv ***
// Far-side serial controller model
`timescale 1ns/1ns
module serial_partner #(
  parameter int BIT_NS = 80
)(
  input  wire logic hclk,
  input  wire logic txd,
  input  wire logic sclk_out,
  output logic      rxd,
  output logic      sclk_in
);
  int   rises;
  logic txd_d;
  initial
  begin
    rxd = 1'b1;
    sclk_in = 1'b1;
  end
  // Line value just before the device clock edge
  always @(negedge hclk) txd_d <= txd;
  always @(posedge sclk_out) rises++;
  task automatic send_async(input logic [11:0] f, input int n);
    for (int i = 0; i < n; i++)
    begin
      rxd = f[i];
      #(BIT_NS);
    end
    rxd = 1'b1;
  endtask : send_async
  task automatic get_async(input int n, output logic [11:0] b, output time t);
    b = 12'h0;
    @(negedge txd);
    t = $time;
    #(BIT_NS / 2);
    b[0] = txd;
    for (int i = 1; i < n; i++)
    begin
      #(BIT_NS);
      b[i] = txd;
    end
  endtask : get_async
  // Clock runs only inside the frame
  task automatic send_sync(input logic [7:0] d, input logic msb);
    for (int i = 0; i < 8; i++)
    begin
      rxd = msb ? d[7 - i] : d[i];
      sclk_in = 1'b0;
      #62;
      sclk_in = 1'b1;
      #63;
    end
    rxd = 1'b1;
  endtask : send_sync
  task automatic get_sync(input logic msb, output logic [7:0] d);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge sclk_out);
      d[msb ? 7 - i : i] = txd_d;
    end
  endtask : get_sync
endmodule : serial_partner

// *** dv/tb.sv ***
// Self-checking bench for the serial channel
`timescale 1ns/1ns
module tb;
  import serial_channel_pkg::*;
  localparam int BAUD = 8;
  logic        hclk, hresetn, hsel, hwrite, dma_busy, hreadyout, hresp;
  logic        rxd, txd, sclk_in, sclk_out, sclk_oe, drx, dtx, rirq, tirq;
  logic        drx3, dtx3, pe, ev, sb, bad, wk;
  logic [1:0]  htrans, m, en;
  logic [7:0]  g;
  logic [8:0]  d;
  logic [11:0] f1, f2, b1, b2;
  logic [23:0] hi;
  logic [31:0] haddr, hwdata, hrdata, rd, r;
  time         t1, t2;
  int          error_cnt, n_compared, seed, nrx, ndrx, ndtx, n3;
  int          e_rx, e_drx, e_dtx, n, k;
  serial_channel #(.CHANNEL(0)) i_serial_channel (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata, .hreadyout, .hresp, .rxd, .txd, .sclk_in, .sclk_out, .sclk_oe,
    .dma_busy, .dma_rx_req(drx), .dma_tx_req(dtx), .receive_irq(rirq),
    .transmit_irq(tirq));
  serial_channel #(.CHANNEL(3)) i_serial_channel_3 (.hclk, .hresetn, .hsel,
    .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout),
    .hrdata(), .hreadyout(), .hresp(), .rxd, .txd(), .sclk_in, .sclk_out(),
    .sclk_oe(), .dma_busy, .dma_rx_req(drx3), .dma_tx_req(dtx3),
    .receive_irq(), .transmit_irq());
  serial_partner #(.BIT_NS(BAUD * 10)) i_serial_partner (.hclk, .txd,
    .sclk_out, .rxd, .sclk_in);
  initial
  begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  always @(posedge hclk)
  begin
    nrx += rirq;
    ndrx += drx;
    ndtx += dtx;
    n3 += drx3 + dtx3;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("MISMATCH at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] v);
    hsel <= 1'b1;
    haddr <= {hi, a};
    hwrite <= w;
    htrans <= 2'b10;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= v;
    @(posedge hclk);
    while (hreadyout !== 1'b1) @(posedge hclk);
    rd = hrdata;
  endtask : xfer
  function automatic logic [11:0] frame(input logic [1:0] m,
                                        input logic [8:0] d,
                                        input logic pe, input logic ev,
                                        output int n);
    logic [11:0] f;
    logic        p;
    int          w;
    w = m == 2'd1 ? 7 : (m == 2'd2 ? 8 : 9);
    f = 12'h0;
    p = !ev;
    for (int i = 0; i < w; i++)
    begin
      f[i + 1] = d[i];
      p ^= d[i];
    end
    n = w + 1;
    if (pe && m != 2'd3)
    begin
      f[n] = p;
      n++;
    end
    f[n] = 1'b1;
    n++;
    return f;
  endfunction : frame
  task automatic finish_test();
    $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : finish_test
  initial
  begin
    #500000;
    error_cnt++;
    $display("MISMATCH at %0t: run did not end", $time);
    finish_test();
  end
  initial
  begin
    seed = 82;
    hi = 24'h0;
    {hresetn, hsel, hwrite, dma_busy} = 4'h0;
    {haddr, hwdata, htrans} = '0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(0, ADDR_TST, 0);
    chk(rd, 32'h80);
    xfer(1, ADDR_TST, '1);
    xfer(0, ADDR_TST, 0);
    chk(rd, 32'h80);
    xfer(1, ADDR_DMA, '1);
    xfer(0, ADDR_DMA, 0);
    chk(rd, 32'h3);
    hi = 24'h1;
    xfer(0, ADDR_DMA, 0);
    chk(rd, 32'h0);
    hi = 24'h0;
    xfer(1, ADDR_BAUD, 32'(BAUD));
    xfer(1, ADDR_MODE, 32'h1);
    repeat (6) xfer(1, ADDR_BUF, $random(seed));
    xfer(0, ADDR_TST, 0);
    chk(rd, 32'h4);
    xfer(1, ADDR_MODE2, 32'h2);
    xfer(0, ADDR_TST, 0);
    chk(rd, 32'h0);
    repeat (150) @(posedge hclk);
    xfer(0, ADDR_TST, 0);
    chk(rd, 32'h80);
    e_dtx = 1;
    $display("test registers and fill done");
    repeat (6)
    begin
      r = $random(seed);
      d = r[24:16];
      m = r[1:0] == 2'd0 ? 2'd2 : r[1:0];
      {sb, ev, pe} = r[4:2];
      en = r[6:5];
      dma_busy <= r[7];
      xfer(1, ADDR_DMA, {30'h0, en});
      xfer(1, ADDR_CTRL, {30'h0, ev, pe});
      xfer(1, ADDR_MODE, {25'h0, d[8], 4'h0, m});
      xfer(1, ADDR_MODE2, {31'h0, sb});
      f1 = frame(m, d, pe, ev, n);
      f2 = frame(m, {d[8], ~d[7:0]}, pe, ev, n);
      xfer(1, ADDR_BUF, {24'h0, d[7:0]});
      xfer(1, ADDR_BUF, {24'h0, ~d[7:0]});
      i_serial_partner.get_async(n, b1, t1);
      i_serial_partner.get_async(n, b2, t2);
      chk({20'h0, b1}, {20'h0, f1});
      chk({20'h0, b2}, {20'h0, f2});
      chk(32'((t2 - t1) / (BAUD * 10)), 32'(n + sb));
      if (en[0] && !r[7]) e_dtx += 2;
      repeat (BAUD * 3) @(posedge hclk);
      dma_busy <= 1'b0;
      xfer(0, m == 2'd1 ? ADDR_CTRL : ADDR_MODE, 0);
      if (pe && m != 2'd3)
        chk(rd[m == 2'd1 ? CR_TB7 : MD_TB8], f2[n - 2]);
      xfer(0, ADDR_TST, 0);
      chk(rd, 32'h80);
    end
    $display("test async transmit done");
    xfer(1, ADDR_MODE2, 32'h1);
    repeat (8)
    begin
      r = $random(seed);
      d = r[24:16];
      m = r[1:0] == 2'd0 ? 2'd3 : r[1:0];
      {wk, bad, ev, pe} = r[5:2];
      en = r[7:6];
      dma_busy <= r[8];
      xfer(1, ADDR_DMA, {30'h0, en});
      xfer(1, ADDR_CTRL, {24'h0, 8'h8c | {6'h0, ev, pe}});
      xfer(1, ADDR_MODE, {26'h0, wk, 1'b1, 2'b00, m});
      f1 = frame(m, d, pe, ev, n);
      f1[n - 2] ^= bad && pe && m != 2'd3;
      i_serial_partner.send_async(f1, n);
      repeat (4) @(posedge hclk);
      dma_busy <= 1'b0;
      if (!(m == 2'd3 && wk && !d[8]))
      begin
        e_rx++;
        if (en[1] && !r[8]) e_drx++;
        xfer(0, ADDR_BUF, 0);
        chk(rd, {24'h0, m == 2'd1 ? f1[8] & pe : d[7], d[6:0]});
        xfer(0, ADDR_CTRL, 0);
        chk(rd[CR_PARITY_ERROR_FLAG], bad && pe && m != 2'd3);
        chk(rd[CR_FIFO_RX_ERROR_SUMMARY], bad && pe && m != 2'd3);
        if (m == 2'd3) chk(rd[CR_RB8], d[8]);
      end
    end
    $display("test async receive done");
    xfer(1, ADDR_DMA, 32'h0);
    for (int i = 0; i < 2; i++)
    begin
      r = $random(seed);
      xfer(1, ADDR_MODE, {29'h1, i[0], 2'b00});
      k = i_serial_partner.rises;
      xfer(1, ADDR_BUF, {24'h0, r[7:0]});
      chk(sclk_oe, 1'b1);
      i_serial_partner.get_sync(i[0], g);
      repeat (BAUD * 8) @(posedge hclk);
      chk(i_serial_partner.rises - k, 8);
      chk(g, r[7:0]);
      xfer(1, ADDR_MODE, {28'h1, 1'b0, i[0], 2'b00});
      i_serial_partner.send_sync(r[15:8], i[0]);
      repeat (6) @(posedge hclk);
      chk(sclk_oe, 1'b0);
      e_rx++;
      xfer(0, ADDR_BUF, 0);
      chk(rd, {24'h0, r[15:8]});
    end
    chk(nrx, e_rx);
    chk(ndrx, e_drx);
    chk(ndtx, e_dtx);
    chk(n3, 0);
    $display("test sync mode and counts done");
    finish_test();
  end
endmodule : tb
bind serial_channel serial_channel_assertions #(.CHANNEL(CHANNEL)) u_chk (
  .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
  .hrdata, .hreadyout, .hresp, .rxd, .txd, .sclk_in, .sclk_out, .sclk_oe,
  .dma_busy, .dma_rx_req, .dma_tx_req, .receive_irq, .transmit_irq);
